// *** rtl/cefb_pkg.sv ***
// package: register map, field layout and reset values of the event bank
package cefb_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLAGS_OFFSET = 8'h03;
  localparam logic [7:0] MASKS_OFFSET = 8'h04;
  // ----------------------------------------------------------------------
  // field positions, shared by flags and masks
  // ----------------------------------------------------------------------
  localparam int HIGH_SIDE_OK_CHANGE_BIT = 7;
  localparam int FLYING_CAP_FAULT_BIT = 6;
  localparam int GATE_SUPPLY_FAULT_BIT = 5;
  localparam int DIRECTION_CHANGE_BIT = 4;
  localparam int CONVERTING_OVERCURRENT_BIT = 3;
  localparam int HIGH_SIDE_OVERCURRENT_BIT = 1;
  localparam int POWER_ON_EVENT_BIT = 0;
  // ----------------------------------------------------------------------
  // reset values and access masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASKS_RESET = 8'h00;
  localparam logic [7:0] MASKS_WRITABLE = 8'hFA;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [6:0] TARGET_ADDRESS_DEFAULT = 7'h2A; // arbitrary value
  // ----------------------------------------------------------------------
  // serial target states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CEFB_IDLE = 3'b000,
    CEFB_ADDR = 3'b001,
    CEFB_PTR = 3'b010,
    CEFB_WDATA = 3'b011,
    CEFB_RDATA = 3'b100
  } cefb_state_type;
endpackage

// *** rtl/cefb_i2c_target.sv ***
// two-wire serial target giving byte register writes and reads
`timescale 1ns/1ps
module cefb_i2c_target import cefb_pkg::*; #(
  parameter logic [6:0] TARGET_ADDRESS = TARGET_ADDRESS_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_reg_write,
  output logic o_reg_read,
  output logic [7:0] o_reg_address,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  // ----------------------------------------------------------------------
  // pin filtering: bit 0 clock line, bit 1 data line
  // ----------------------------------------------------------------------
  logic [1:0] s1, s2, s3, filt, filt_d;
  logic scl, sda, scl_rise, scl_fall, start, stop;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      filt <= 2'h3;
      filt_d <= 2'h3;
    end else begin
      s1 <= {i_sda, i_scl};
      s2 <= s1;
      s3 <= s2;
      // a change is taken only once the second and third stages agree
      filt <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
      filt_d <= filt;
    end
  end
  assign scl = filt[0];
  assign sda = filt[1];
  assign scl_rise = scl & ~filt_d[0];
  assign scl_fall = ~scl & filt_d[0];
  assign start = scl & filt_d[0] & ~sda & filt_d[1];
  assign stop = scl & filt_d[0] & sda & ~filt_d[1];
  // ----------------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------------
  cefb_state_type state;
  logic [2:0] count;
  logic [7:0] shift;
  logic in_ack, byte_done, rw;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= CEFB_IDLE;
      count <= 3'h0;
      shift <= 8'h00;
      in_ack <= 1'b0;
      byte_done <= 1'b0;
      rw <= 1'b0;
      o_sda_oe <= 1'b0;
      o_reg_write <= 1'b0;
      o_reg_read <= 1'b0;
      o_reg_address <= 8'h00;
      o_reg_wdata <= 8'h00;
    end else begin
      o_reg_write <= 1'b0;
      o_reg_read <= 1'b0;
      if (start) begin
        state <= CEFB_ADDR;
        count <= 3'h0;
        in_ack <= 1'b0;
        byte_done <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop) begin
        state <= CEFB_IDLE;
        in_ack <= 1'b0;
        byte_done <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (in_ack) begin
          // read data is fetched at the ack, well before the next fall
          if (state == CEFB_RDATA) begin
            if (sda) state <= CEFB_IDLE;
            else o_reg_read <= 1'b1;
          end else if (state == CEFB_ADDR && rw) begin
            o_reg_read <= 1'b1;
          end
        end else if (state != CEFB_IDLE) begin
          shift <= {shift[6:0], sda};
          count <= count + 3'h1;
          if (count == 3'h7) begin
            byte_done <= 1'b1;
            unique case (state)
              CEFB_ADDR: begin
                rw <= sda;
                if (shift[6:0] != TARGET_ADDRESS) state <= CEFB_IDLE;
              end
              CEFB_PTR: o_reg_address <= {shift[6:0], sda};
              CEFB_WDATA: begin
                o_reg_write <= 1'b1;
                o_reg_wdata <= {shift[6:0], sda};
              end
              CEFB_RDATA: ;
              CEFB_IDLE: ;
            endcase
          end
        end
      end else if (scl_fall) begin
        if (byte_done) begin
          byte_done <= 1'b0;
          in_ack <= (state != CEFB_IDLE);
          o_sda_oe <= (state != CEFB_IDLE) && (state != CEFB_RDATA);
        end else if (in_ack) begin
          in_ack <= 1'b0;
          count <= 3'h0;
          o_sda_oe <= 1'b0;
          unique case (state)
            CEFB_ADDR: begin
              state <= rw ? CEFB_RDATA : CEFB_PTR;
              if (rw) begin
                shift <= i_reg_rdata;
                o_sda_oe <= ~i_reg_rdata[7];
                o_reg_address <= o_reg_address + 8'h01;
              end
            end
            CEFB_PTR: state <= CEFB_WDATA;
            CEFB_WDATA: o_reg_address <= o_reg_address + 8'h01;
            CEFB_RDATA: begin
              shift <= i_reg_rdata;
              o_sda_oe <= ~i_reg_rdata[7];
              o_reg_address <= o_reg_address + 8'h01;
            end
            CEFB_IDLE: ;
          endcase
        end else if (state == CEFB_RDATA) begin
          o_sda_oe <= ~shift[7];
        end
      end
    end
  end
  // open drain: the line is only ever pulled low
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) o_sda_out <= 1'b0;
    else o_sda_out <= 1'b0;
  end
endmodule // cefb_i2c_target

// *** rtl/cefb_event_flags.sv ***
// second bank of converter event flags, masks and interrupt request
// Notes on behaviour
// - supply-ok change in either direction sets flag 7, interrupt if unmasked
// - flying capacitor charging fault sets flag 6, interrupt if unmasked
// - gate supply charging fault sets flag 5, interrupt if unmasked
// - direction change forward/reverse sets flag 4, interrupt if unmasked
// - over-current while converting sets flag 3, interrupt if unmasked
// - level-one trip in reverse or level-two trip sets flag 1
// - supply above threshold while enabled, or adapter rising, sets flag 0
// - flags clear only by being read by the host
// - a set mask bit keeps the flag latching but blocks the interrupt
// - masks align with flags; mask bits 2 and 0 read zero
// - masks reset to zero, also on hard, register or watchdog reset
// - flags power up zero, bit 2 stays zero, soft resets leave them
// - direction status reads 0 forward, 1 reverse; it drives flag 4
`timescale 1ns/1ps
module cefb_event_flags import cefb_pkg::*; #(
  parameter logic [6:0] TARGET_ADDRESS = TARGET_ADDRESS_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_high_side_supply_ok,
  input wire logic i_switching_direction_status,
  input wire logic i_flying_cap_fault,
  input wire logic i_gate_supply_fault,
  input wire logic i_converting_overcurrent,
  input wire logic i_low_side_limit_level_one,
  input wire logic i_high_side_limit_level_two,
  input wire logic i_supply_above_uvlo,
  input wire logic i_chip_enabled,
  input wire logic i_adapter_input_ok,
  input wire logic i_hard_reset,
  input wire logic i_register_reset,
  input wire logic i_watchdog_expiry,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_interrupt_request_out_n,
  output logic o_switching_direction_status
);
  // ----------------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------------
  logic reg_write, reg_read;
  logic [7:0] reg_address, reg_wdata, reg_rdata;
  cefb_i2c_target #(.TARGET_ADDRESS(TARGET_ADDRESS)) u_target (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_reg_write(reg_write),
    .o_reg_read(reg_read),
    .o_reg_address(reg_address),
    .o_reg_wdata(reg_wdata),
    .i_reg_rdata(reg_rdata)
  );
  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    hits = (a == off);
  endfunction
  // ----------------------------------------------------------------------
  // detector inputs: 0 supply ok, 1 direction, 2 flying cap, 3 gate supply,
  // 4 converting ocp, 5 level one, 6 level two, 7 uvlo, 8 enabled, 9 adapter
  // ----------------------------------------------------------------------
  logic [9:0] s1, s2, s3, filt, filt_d, next_filt;
  assign next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s1 <= 10'h000;
      s2 <= 10'h000;
      s3 <= 10'h000;
      filt <= 10'h000;
      filt_d <= 10'h000;
    end else begin
      s1 <= {i_adapter_input_ok, i_chip_enabled, i_supply_above_uvlo,
             i_high_side_limit_level_two, i_low_side_limit_level_one,
             i_converting_overcurrent, i_gate_supply_fault,
             i_flying_cap_fault, i_switching_direction_status,
             i_high_side_supply_ok};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      filt_d <= filt;
    end
  end
  logic [9:0] rise, change;
  logic power_on_now, power_on_was;
  logic [7:0] events;
  assign rise = filt & ~filt_d;
  assign change = filt ^ filt_d;
  assign power_on_now = filt[7] & filt[8];
  assign power_on_was = filt_d[7] & filt_d[8];
  always_comb begin
    events = 8'h00;
    events[HIGH_SIDE_OK_CHANGE_BIT] = change[0];
    events[FLYING_CAP_FAULT_BIT] = rise[2];
    events[GATE_SUPPLY_FAULT_BIT] = rise[3];
    events[DIRECTION_CHANGE_BIT] = change[1];
    events[CONVERTING_OVERCURRENT_BIT] = rise[4];
    events[HIGH_SIDE_OVERCURRENT_BIT] = (rise[5] & filt[1]) | rise[6];
    events[POWER_ON_EVENT_BIT] = (power_on_now & ~power_on_was)
                                 | rise[9];
  end
  // ----------------------------------------------------------------------
  // flags, masks and read data
  // ----------------------------------------------------------------------
  logic [7:0] flags, masks;
  logic flag_read, soft_reset;
  assign flag_read = reg_read && hits(reg_address, FLAGS_OFFSET);
  assign soft_reset = i_hard_reset | i_register_reset | i_watchdog_expiry;
  // only the bits handed to the host are cleared, and a new event wins
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) flags <= FLAGS_RESET;
    else flags <= (flags & ~(flag_read ? flags : 8'h00)) | events;
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) masks <= MASKS_RESET;
    else if (soft_reset) masks <= MASKS_RESET;
    else if (reg_write && hits(reg_address, MASKS_OFFSET))
      masks <= reg_wdata & MASKS_WRITABLE;
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) reg_rdata <= UNMAPPED_READ;
    else if (reg_read) begin
      if (flag_read) reg_rdata <= flags;
      else if (hits(reg_address, MASKS_OFFSET)) reg_rdata <= masks;
      else reg_rdata <= UNMAPPED_READ;
    end
  end
  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // unmaskable flags see a mask bit that is always zero
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) o_interrupt_request_out_n <= 1'b1;
    else o_interrupt_request_out_n <= ~|(flags & ~masks);
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) o_switching_direction_status <= 1'b0;
    else o_switching_direction_status <= filt[1];
  end
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_host_reads_flags;
    flag_read;
  endsequence
  sequence s_flag_seen_later(int k);
    ##1 flags[k];
  endsequence
  a_supply_ok_change: assert property (change[0] |->
    s_flag_seen_later(HIGH_SIDE_OK_CHANGE_BIT))
    else $error("supply ok change did not set its flag");
  a_flying_cap_set: assert property (rise[2] |->
    s_flag_seen_later(FLYING_CAP_FAULT_BIT))
    else $error("flying cap fault did not set its flag");
  a_gate_fault_set: assert property (rise[3] |->
    s_flag_seen_later(GATE_SUPPLY_FAULT_BIT))
    else $error("gate supply fault did not set its flag");
  a_direction_flag_set: assert property ($changed(filt[1]) |->
    s_flag_seen_later(DIRECTION_CHANGE_BIT))
    else $error("direction change did not set its flag");
  a_conv_ocp_set: assert property (rise[4] |->
    s_flag_seen_later(CONVERTING_OVERCURRENT_BIT))
    else $error("converting over-current did not set its flag");
  a_high_ocp_set: assert property (
    (rise[6] || (rise[5] && filt[1])) |->
    s_flag_seen_later(HIGH_SIDE_OVERCURRENT_BIT))
    else $error("high side over-current did not set its flag");
  a_power_on_set: assert property ($rose(power_on_now) || rise[9] |->
    s_flag_seen_later(POWER_ON_EVENT_BIT))
    else $error("power-on event did not set its flag");
  a_flags_read_clear: assert property (!flag_read |=>
    ((flags & $past(flags)) == $past(flags)))
    else $error("flag cleared without a host read");
  a_read_clears_bits: assert property (s_host_reads_flags ##0 events == 8'h00
    |=> flags == 8'h00 ##1 !o_interrupt_request_out_n == 1'b0)
    else $error("read did not clear reported flags");
  a_mask_blocks_irq: assert property ((flags & ~masks) == 8'h00
    |=> o_interrupt_request_out_n)
    else $error("masked flag raised the request");
  a_mask_reserved_zero: assert property (
    (masks & ~MASKS_WRITABLE) == 8'h00)
    else $error("reserved mask bit set");
  a_mask_soft_reset: assert property (
    soft_reset |=> masks == MASKS_RESET)
    else $error("masks not cleared by reset source");
  a_flag_bit_two: assert property (
    flags[2] == 1'b0)
    else $error("reserved flag bit set");
  a_direction_status: assert property (
    filt[1] |=> o_switching_direction_status)
    else $error("direction status not reported");
  a_request_asserted: assert property ((flags & ~masks) != 8'h00
    |=> !o_interrupt_request_out_n)
    else $error("enabled flag did not raise the request");
endmodule // cefb_event_flags

// *** dv/cefb_host_model.sv ***
// host-side two-wire master model that reports each byte it reads back
`timescale 1ns/1ps
module cefb_host_model import cefb_pkg::*; #(
  parameter logic [6:0] TARGET_ADDRESS = TARGET_ADDRESS_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe,
  output logic o_valid,
  output logic [7:0] o_byte
);
  // ----------------------------------------------------------------------
  // bit, byte and frame sequencing, five clocks per clock half
  // ----------------------------------------------------------------------
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    o_valid = 1'b0;
    o_byte = 8'h00;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // data moves two clocks after the clock fall so it never looks like a start
  task automatic bit_xfer(input logic b, output logic r);
    wait_clk(2);
    o_sda_oe = ~b;
    wait_clk(3);
    o_scl = 1'b1;
    wait_clk(5);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic byte_xfer(input logic [7:0] d, input logic ack_n,
                           output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
    bit_xfer(ack_n, a);
  endtask
  task automatic edge_cond(input logic first_oe, input logic last_oe);
    wait_clk(2);
    o_sda_oe = first_oe;
    wait_clk(3);
    o_scl = 1'b1;
    wait_clk(5);
    o_sda_oe = last_oe;
    wait_clk(5);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    edge_cond(1'b0, 1'b1);
    o_scl = 1'b0;
    byte_xfer({TARGET_ADDRESS, 1'b0}, 1'b1, q);
    byte_xfer(a, 1'b1, q);
    byte_xfer(d, 1'b1, q);
    edge_cond(1'b1, 1'b0);
  endtask
  // the host acknowledges events only by reading the flags
  task automatic read_reg(input logic [7:0] a);
    logic [7:0] q;
    edge_cond(1'b0, 1'b1);
    o_scl = 1'b0;
    byte_xfer({TARGET_ADDRESS, 1'b0}, 1'b1, q);
    byte_xfer(a, 1'b1, q);
    edge_cond(1'b0, 1'b1);
    o_scl = 1'b0;
    byte_xfer({TARGET_ADDRESS, 1'b1}, 1'b1, q);
    byte_xfer(8'hFF, 1'b1, q);
    edge_cond(1'b1, 1'b0);
    o_byte = q;
    o_valid = 1'b1;
    wait_clk(1);
    o_valid = 1'b0;
  endtask
endmodule // cefb_host_model

// *** dv/tb_cefb_event_flags.sv ***
// self-checking bench for the second event flag bank
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_cefb_event_flags import cefb_pkg::*; ();
  // ----------------------------------------------------------------------
  // stimulus, pin wiring and result checking
  // ----------------------------------------------------------------------
  localparam logic [9:0] SEQ_V [17] = '{10'h001, 10'h000, 10'h002, 10'h022,
    10'h002, 10'h000, 10'h020, 10'h000, 10'h004, 10'h008, 10'h010, 10'h040,
    10'h200, 10'h000, 10'h080, 10'h180, 10'h000};
  localparam logic [7:0] SEQ_F [17] = '{8'h80, 8'h80, 8'h10, 8'h02, 8'h00,
    8'h10, 8'h00, 8'h00, 8'h40, 8'h20, 8'h08, 8'h02, 8'h01, 8'h00, 8'h00,
    8'h01, 8'h00};
  logic i_clock;
  logic i_resetn;
  logic [9:0] ev;
  logic hard_rst, reg_rst, wdt_rst;
  logic host_scl, host_oe, rd_valid, dut_out, dut_oe, irq_n, dir_status;
  logic [7:0] rd_byte;
  logic [7:0] exp_b;
  logic [7:0] exp_q [$];
  logic [31:0] rng = 32'h0000_9DC7;
  logic sda;
  int k;
  int n_mismatch = 0;
  int check_count = 0;
  // open-drain data line with a pull-up
  assign sda = ~(host_oe | (dut_oe & ~dut_out));
  cefb_event_flags u_cefb_event_flags (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_scl(host_scl), .i_sda(sda),
    .i_high_side_supply_ok(ev[0]), .i_switching_direction_status(ev[1]),
    .i_flying_cap_fault(ev[2]), .i_gate_supply_fault(ev[3]),
    .i_converting_overcurrent(ev[4]), .i_low_side_limit_level_one(ev[5]),
    .i_high_side_limit_level_two(ev[6]), .i_supply_above_uvlo(ev[7]),
    .i_chip_enabled(ev[8]), .i_adapter_input_ok(ev[9]),
    .i_hard_reset(hard_rst), .i_register_reset(reg_rst),
    .i_watchdog_expiry(wdt_rst), .o_sda_out(dut_out), .o_sda_oe(dut_oe),
    .o_interrupt_request_out_n(irq_n),
    .o_switching_direction_status(dir_status));
  cefb_host_model u_cefb_host_model (
    .i_clock(i_clock), .i_sda(sda), .o_scl(host_scl), .o_sda_oe(host_oe),
    .o_valid(rd_valid), .o_byte(rd_byte));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_cefb_host_model.read_reg(a);
  endtask
  // m is the mask as read back; flag 0 has no mask and always interrupts
  task automatic step(input logic [9:0] v, input logic [7:0] f,
                      input logic [7:0] m);
    ev = v;
    repeat (10) @(negedge i_clock);
    `CHECK(irq_n, ~|(f & {~m[7:1], 1'b1}))
    `CHECK(dir_status, v[1])
    rd(FLAGS_OFFSET, f);
    rd(FLAGS_OFFSET, 8'h00);
    `CHECK(irq_n, 1'b1)
  endtask
  always @(posedge i_clock) begin
    if (rd_valid === 1'b1) begin
      // an unexpected byte must fail, so compare against its own inverse
      exp_b = exp_q.size() > 0 ? exp_q.pop_front() : ~rd_byte;
      `CHECK(rd_byte, exp_b)
    end
  end
  initial begin
    repeat (90000) @(posedge i_clock);
    n_mismatch++;
    $display("mismatch at %0t: run timed out", $time);
    finish_test();
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_resetn = 1'b0;
    ev = 10'h000;
    {wdt_rst, reg_rst, hard_rst} = 3'h0;
    repeat (20) @(negedge i_clock);
    i_resetn = 1'b1;
    repeat (5) @(negedge i_clock);
    `CHECK(irq_n, 1'b1)
    rd(FLAGS_OFFSET, FLAGS_RESET);
    rd(MASKS_OFFSET, MASKS_RESET);
    for (int i = 0; i < 17; i++) step(SEQ_V[i], SEQ_F[i], 8'h00);
    u_cefb_host_model.write_reg(MASKS_OFFSET, 8'hFF);
    rd(MASKS_OFFSET, MASKS_WRITABLE);
    u_cefb_host_model.write_reg(FLAGS_OFFSET, 8'hFF);
    rd(FLAGS_OFFSET, 8'h00);
    rd(8'h05, UNMAPPED_READ);
    for (int i = 0; i < 17; i++) step(SEQ_V[i], SEQ_F[i], 8'hFA);
    for (int i = 0; i < 6; i++) begin
      rng = xorshift(rng);
      k = 8 + int'(rng[9:8]);
      u_cefb_host_model.write_reg(MASKS_OFFSET, rng[7:0]);
      rd(MASKS_OFFSET, rng[7:0] & MASKS_WRITABLE);
      step(SEQ_V[k], SEQ_F[k], rng[7:0] & MASKS_WRITABLE);
      step(10'h000, 8'h00, 8'h00);
    end
    // every soft reset source clears the masks but keeps pending flags
    for (int i = 0; i < 3; i++) begin
      u_cefb_host_model.write_reg(MASKS_OFFSET, 8'hFF);
      ev = 10'h004;
      repeat (10) @(negedge i_clock);
      `CHECK(irq_n, 1'b1)
      {wdt_rst, reg_rst, hard_rst} = 3'h1 << i;
      @(negedge i_clock);
      {wdt_rst, reg_rst, hard_rst} = 3'h0;
      repeat (3) @(negedge i_clock);
      `CHECK(irq_n, 1'b0)
      rd(MASKS_OFFSET, MASKS_RESET);
      rd(FLAGS_OFFSET, 8'h40);
      ev = 10'h000;
    end
    repeat (5) @(negedge i_clock);
    `CHECK(exp_q.size(), 0)
    finish_test();
  end
endmodule // tb_cefb_event_flags
